//--- rtl/sps_pkg.sv
package sps_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned T_I2C_RDY_MS = 2;
  localparam int unsigned T_HRST_MS = 2;
  localparam int unsigned T_TMDS_US = 1;
  localparam int unsigned I2C_HZ = 100_000;
  localparam int unsigned I2C_RDY_CYC_DEF = T_I2C_RDY_MS * (CLK_HZ / 1_000);
  localparam int unsigned HRST_CYC_DEF = T_HRST_MS * (CLK_HZ / 1_000);
  localparam int unsigned TMDS_CYC = (T_TMDS_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned I2C_QTR_CYC = CLK_HZ / (4 * I2C_HZ);
  localparam int unsigned TMR_W = 15;
  localparam int unsigned QCNT_W = 5;

  // ****************************************
  // Device registers and values
  // ****************************************
  localparam logic [7:0] REG_EVT_FILT = 8'h16;
  localparam logic [7:0] REG_PAGE_SEL = 8'h40;
  localparam logic [7:0] REG_PAGE_OFS = 8'h41;
  localparam logic [7:0] REG_PAGE_DATA = 8'h42;
  localparam logic [7:0] REG_FREQ_RST = 8'h5b;
  localparam logic [7:0] FREQ_RST_CLR_MASK = 8'hdf;
  localparam logic [7:0] EVT_FILT_VAL = 8'h02;
  localparam logic [7:0] PAGE_HDMI = 8'h10;
  localparam logic [7:0] PAGE_LINK = 8'h14;
  localparam logic [7:0] PLL_SM_OFS = 8'h49;
  localparam logic [7:0] SM_RESET_ON = 8'h10;
  localparam logic [7:0] SM_RESET_OFF = 8'h00;
  localparam logic [3:0] NUM_WR = 4'ha;
  localparam logic [3:0] LAST_A = 4'h1;

  // ****************************************
  // I2C framing and input sync
  // ****************************************
  localparam int unsigned FRAME_BITS = 27;
  localparam logic [4:0] LAST_BIT = 5'h1a;
  localparam logic [6:0] I2C_DEV_ADDR_DEF = 7'h2a;  // Value arbitrary
  localparam int unsigned SY_W = 5;
  localparam int unsigned SY_TMDS = 3;
  localparam int unsigned SY_SDA = 4;
  localparam logic [2:0] PG_ALL = 3'h7;

  typedef enum logic [11:0] {
    S_OFF     = 12'h001,
    S_SUP18   = 12'h002,
    S_SUPTERM = 12'h004,
    S_SUP11   = 12'h008,
    S_HOLD    = 12'h010,
    S_RDY     = 12'h020,
    S_INITA   = 12'h040,
    S_TMDS    = 12'h080,
    S_INITB   = 12'h100,
    S_DONE    = 12'h200,
    S_ERR     = 12'h400
  } sps_st_e;

  typedef enum logic [3:0] {
    I_IDLE  = 4'h1,
    I_START = 4'h2,
    I_BIT   = 4'h4,
    I_STOP  = 4'h8
  } sps_i2c_e;

  // Register address and data of write number idx
  function automatic logic [15:0] sps_entry(input logic [3:0] idx, input logic [7:0] cfg);
    case (idx)
      4'h0: sps_entry = {REG_FREQ_RST, cfg & FREQ_RST_CLR_MASK};
      4'h1: sps_entry = {REG_EVT_FILT, EVT_FILT_VAL};
      4'h2: sps_entry = {REG_PAGE_SEL, PAGE_HDMI};
      4'h3: sps_entry = {REG_PAGE_OFS, PLL_SM_OFS};
      4'h4: sps_entry = {REG_PAGE_DATA, SM_RESET_ON};
      4'h5: sps_entry = {REG_PAGE_DATA, SM_RESET_OFF};
      4'h6: sps_entry = {REG_PAGE_SEL, PAGE_LINK};
      4'h7: sps_entry = {REG_PAGE_OFS, PLL_SM_OFS};
      4'h8: sps_entry = {REG_PAGE_DATA, SM_RESET_ON};
      default: sps_entry = {REG_PAGE_DATA, SM_RESET_OFF};
    endcase
  endfunction

endpackage

//--- rtl/sps_ctrl.sv
`timescale 1ns/1ps
module sps_ctrl #(
  parameter int unsigned I2C_RDY_CYC = sps_pkg::I2C_RDY_CYC_DEF,
  parameter int unsigned HRST_CYC = sps_pkg::HRST_CYC_DEF,
  parameter logic [6:0] I2C_DEV_ADDR = sps_pkg::I2C_DEV_ADDR_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User orders and status
  input wire logic run_en,
  input wire logic hard_reset_req,
  input wire logic [7:0] freq_rst_cfg,
  output logic seq_ready,
  output logic seq_busy,
  output logic seq_error,
  // Supplies
  output logic supply_1v8_en,
  output logic termination_supply_en,
  output logic supply_1v1_en,
  input wire logic [2:0] supply_good,
  // Device pins
  output logic power_down_n_pin,
  output logic hdmi_input_en,
  output logic gpio_release,
  input wire logic tmds_clk_stable,
  // I2C, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  import sps_pkg::*;

  sps_st_e st_q;
  sps_i2c_e ist_q;
  logic [SY_W-1:0] s1_q, s2_q, s3_q, flt_q;
  logic [QCNT_W-1:0] qcnt_q;
  logic tick_q;
  logic [TMR_W-1:0] tmr_q;
  logic [3:0] idx_q;
  logic go_q, done_q, nack_q;
  logic [1:0] q_q;
  logic [4:0] bit_q;
  logic [FRAME_BITS-1:0] sh_q;
  logic [15:0] ent;
  logic pg_ok, powered, in_init;

  assign pg_ok = (flt_q[2:0] == PG_ALL);
  assign powered = st_q inside {S_HOLD, S_RDY, S_INITA, S_TMDS, S_INITB, S_DONE, S_ERR};
  assign in_init = st_q inside {S_INITA, S_INITB};
  assign ent = sps_entry(idx_q, freq_rst_cfg);

  // ****************************************
  // Pin input filter
  // ****************************************
  // A change counts only once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      flt_q <= '0;
    end else begin
      s1_q <= {sda_i, tmds_clk_stable, supply_good};
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
    end
  end

  // ****************************************
  // I2C quarter-bit enable
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qcnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (qcnt_q == QCNT_W'(I2C_QTR_CYC - 1));
      qcnt_q <= (qcnt_q == QCNT_W'(I2C_QTR_CYC - 1)) ? '0 : qcnt_q + 1'b1;
    end
  end

  // ****************************************
  // Power and init sequencer
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_OFF;
      tmr_q <= '0;
      idx_q <= '0;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      tmr_q <= (&tmr_q) ? tmr_q : tmr_q + 1'b1;
      if (!run_en || (powered && !pg_ok)) begin
        st_q <= S_OFF;
        tmr_q <= '0;
      end else if (hard_reset_req &&
                   st_q inside {S_RDY, S_INITA, S_TMDS, S_INITB, S_DONE, S_ERR}) begin
        st_q <= S_HOLD;
        tmr_q <= '0;
      end else begin
        case (st_q)
          S_OFF: begin
            st_q <= S_SUP18;
          end
          S_SUP18: begin
            if (flt_q[0]) begin
              st_q <= S_SUPTERM;
            end
          end
          S_SUPTERM: begin
            if (flt_q[1]) begin
              st_q <= S_SUP11;
            end
          end
          S_SUP11: begin
            if (flt_q[2]) begin
              st_q <= S_HOLD;
              tmr_q <= '0;
            end
          end
          S_HOLD: begin
            // Doubles as the hard reset pulse, so every restart is a clean reset
            if (tmr_q >= TMR_W'(HRST_CYC - 1)) begin
              st_q <= S_RDY;
              tmr_q <= '0;
            end
          end
          S_RDY: begin
            if (tmr_q >= TMR_W'(I2C_RDY_CYC)) begin
              st_q <= S_INITA;
              idx_q <= '0;
              go_q <= 1'b1;
            end
          end
          S_TMDS: begin
            if (!flt_q[SY_TMDS]) begin
              tmr_q <= '0;
            end else if (tmr_q >= TMR_W'(TMDS_CYC)) begin
              st_q <= S_INITB;
              go_q <= 1'b1;
            end
          end
          S_INITA, S_INITB: begin
            if (done_q) begin
              if (nack_q) begin
                st_q <= S_ERR;
              end else if (idx_q == LAST_A && st_q == S_INITA) begin
                st_q <= S_TMDS;
                idx_q <= idx_q + 1'b1;
                tmr_q <= '0;
              end else if (idx_q == NUM_WR - 1'b1) begin
                st_q <= S_DONE;
              end else begin
                idx_q <= idx_q + 1'b1;
                go_q <= 1'b1;
              end
            end
          end
          S_DONE, S_ERR: begin
            st_q <= st_q;
          end
          default: begin
            st_q <= S_OFF;
          end
        endcase
      end
    end
  end

  // ****************************************
  // I2C write engine
  // ****************************************
  // Write only; clock stretching by the device is not honoured
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ist_q <= I_IDLE;
      q_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (!in_init) begin
        ist_q <= I_IDLE;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
      end else if (go_q) begin
        ist_q <= I_START;
        q_q <= '0;
        bit_q <= '0;
        nack_q <= 1'b0;
        sh_q <= {I2C_DEV_ADDR, 1'b0, 1'b1, ent[15:8], 1'b1, ent[7:0], 1'b1};
      end else if (tick_q && ist_q != I_IDLE) begin
        q_q <= q_q + 1'b1;
        case (ist_q)
          I_START: begin
            case (q_q)
              2'h0: sda_oe_n <= 1'b1;
              2'h1: sda_oe_n <= 1'b0;
              2'h2: scl_oe_n <= 1'b0;
              default: ist_q <= I_BIT;
            endcase
          end
          I_BIT: begin
            case (q_q)
              2'h0: sda_oe_n <= sh_q[FRAME_BITS-1];
              2'h1: scl_oe_n <= 1'b1;
              2'h2: begin
                if (sh_q[FRAME_BITS-1] && flt_q[SY_SDA] &&
                    bit_q inside {5'h08, 5'h11, LAST_BIT}) begin
                  nack_q <= 1'b1;
                end
              end
              default: begin
                scl_oe_n <= 1'b0;
                sh_q <= {sh_q[FRAME_BITS-2:0], 1'b1};
                bit_q <= bit_q + 1'b1;
                if (bit_q == LAST_BIT) begin
                  ist_q <= I_STOP;
                end
              end
            endcase
          end
          I_STOP: begin
            case (q_q)
              2'h0: sda_oe_n <= 1'b0;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b1;
              default: begin
                ist_q <= I_IDLE;
                done_q <= 1'b1;
              end
            endcase
          end
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      supply_1v8_en <= 1'b0;
      termination_supply_en <= 1'b0;
      supply_1v1_en <= 1'b0;
      power_down_n_pin <= 1'b0;
      hdmi_input_en <= 1'b0;
      gpio_release <= 1'b0;
      seq_ready <= 1'b0;
      seq_busy <= 1'b0;
      seq_error <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      supply_1v8_en <= (st_q != S_OFF);
      termination_supply_en <= !(st_q inside {S_OFF, S_SUP18});
      supply_1v1_en <= !(st_q inside {S_OFF, S_SUP18, S_SUPTERM});
      power_down_n_pin <= powered && st_q != S_HOLD;
      hdmi_input_en <= power_down_n_pin && powered && st_q != S_HOLD;
      gpio_release <= power_down_n_pin && powered && st_q != S_HOLD;
      seq_ready <= (st_q == S_DONE);
      seq_busy <= !(st_q inside {S_OFF, S_DONE, S_ERR});
      seq_error <= (st_q == S_ERR);
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [TMR_W-1:0] hi_cnt_q, lo_cnt_q;
  logic [3:0] wr_cnt_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_q <= '0;
      lo_cnt_q <= '0;
      wr_cnt_q <= '0;
    end else begin
      hi_cnt_q <= !power_down_n_pin ? '0 : ((&hi_cnt_q) ? hi_cnt_q : hi_cnt_q + 1'b1);
      lo_cnt_q <= power_down_n_pin ? '0 : ((&lo_cnt_q) ? lo_cnt_q : lo_cnt_q + 1'b1);
      wr_cnt_q <= (st_q == S_HOLD) ? '0 : wr_cnt_q + 4'(done_q && !nack_q);
    end
  end

  sequence s_release;
    !power_down_n_pin ##1 power_down_n_pin;
  endsequence

  AST_TERM_AFTER_1V8: assert property (@(posedge clk) disable iff (!resetn)
    $rose(termination_supply_en) |-> supply_1v8_en)
    else $error("Termination supply enabled before 1v8");
  AST_1V1_LAST: assert property (@(posedge clk) disable iff (!resetn)
    $rose(supply_1v1_en) |-> termination_supply_en && $past(flt_q[1]))
    else $error("1v1 supply enabled out of order");
  AST_PDN_SUPPLIES: assert property (@(posedge clk) disable iff (!resetn)
    s_release |-> supply_1v1_en && $past(pg_ok))
    else $error("Power-down released before supplies good");
  AST_HARD_RESET: assert property (@(posedge clk) disable iff (!resetn)
    s_release |-> $past(lo_cnt_q) >= TMR_W'(HRST_CYC - 1))
    else $error("Power-down low pulse too short");
  AST_I2C_WAIT: assert property (@(posedge clk) disable iff (!resetn)
    $fell(sda_oe_n) |-> hi_cnt_q >= TMR_W'(I2C_RDY_CYC))
    else $error("I2C access before ready time");
  AST_I2C_QUIET: assert property (@(posedge clk) disable iff (!resetn)
    !power_down_n_pin |-> ##1 (scl_oe_n && sda_oe_n))
    else $error("I2C driven while device held down");
  AST_GPIO_STATIC: assert property (@(posedge clk) disable iff (!resetn)
    gpio_release |-> power_down_n_pin)
    else $error("GPIO released before power-down release");
  AST_INITB_TMDS: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == S_TMDS && $past(st_q) == S_TMDS) ##1 (st_q == S_INITB) |-> $past(flt_q[SY_TMDS], 2))
    else $error("Sequence B started without stable TMDS clock");
  AST_ALL_WRITES: assert property (@(posedge clk) disable iff (!resetn)
    $rose(seq_ready) |-> wr_cnt_q == NUM_WR)
    else $error("Init finished without all ten writes");
  AST_SUPPLY_LOSS: assert property (@(posedge clk) disable iff (!resetn)
    (powered && !pg_ok && run_en) |-> ##[1:2] !power_down_n_pin)
    else $error("Power-down not asserted after supply loss");

endmodule

//--- dv/sps_dev_model.sv
`timescale 1ns/1ps
module sps_dev_model #(
  parameter int unsigned RDY_CYC = 40,
  parameter int unsigned RST_CYC = 40,
  parameter int unsigned TMDS_CYC = 10,
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // Clock
  input wire logic clk,
  // Supplies
  input wire logic supply_1v8_en,
  input wire logic termination_supply_en,
  input wire logic supply_1v1_en,
  input wire logic [7:0] ramp_cyc,
  input wire logic supply_drop,
  output logic [2:0] supply_good,
  // Device pins
  input wire logic power_down_n_pin,
  input wire logic hdmi_input_en,
  input wire logic gpio_release,
  input wire logic tmds_clk_stable,
  input wire logic nack_en,
  // I2C wires
  input wire logic scl,
  input wire logic sda,
  output logic sda_dev
);
  logic [7:0] regs [256];
  logic [15:0] wr_q [$];
  logic [7:0] sh;
  logic [7:0] reg_a;
  logic ack;
  logic in_frame = 1'b0;
  int errs = 0;
  int hdmi_pll_rst = 0;
  int link_pll_rst = 0;
  int up_cnt = 0;
  int low_cnt = 0;
  int tmds_cnt = 0;
  int bitn = 0;
  int byten = 0;
  int ramp [3] = '{0, 0, 0};
  wire [2:0] en_w = {supply_1v1_en, termination_supply_en, supply_1v8_en};

  // ****************************************
  // Supplies and pin timing
  // ****************************************
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) ramp[i] <= en_w[i] ? ramp[i] + 1 : 0;
    up_cnt <= power_down_n_pin ? up_cnt + 1 : 0;
    low_cnt <= power_down_n_pin ? 0 : low_cnt + 1;
    tmds_cnt <= tmds_clk_stable ? tmds_cnt + 1 : 0;
    if ($rose(termination_supply_en) && !supply_good[0]) errs++;
    if ($rose(supply_1v1_en) && !supply_good[1]) errs++;
    if ($rose(power_down_n_pin) && supply_good != 3'h7) errs++;
    if ($rose(power_down_n_pin) && low_cnt < RST_CYC) errs++;
    if (($rose(hdmi_input_en) || $rose(gpio_release)) && !power_down_n_pin) errs++;
  end

  always_comb begin
    for (int j = 0; j < 3; j++) supply_good[j] = ramp[j] > int'(ramp_cyc) && !supply_drop;
  end

  // Power-down loses all register contents
  always @(negedge power_down_n_pin) begin
    foreach (regs[k]) regs[k] = 8'h00;
    in_frame = 1'b0;
    // A device powered down mid acknowledge must let go of the data line
    sda_dev = 1'b1;
  end

  // ****************************************
  // Register window
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_q.push_back({a, d});
    regs[a] = d;
    if (a == 8'h40 && tmds_cnt < TMDS_CYC) errs++;
    if (a == 8'h42 && regs[8'h41] == 8'h49) begin
      if (d[3:0] != 4'h0) errs++;
      if (d == 8'h10 && regs[8'h40] == 8'h10) hdmi_pll_rst++;
      if (d == 8'h10 && regs[8'h40] == 8'h14) link_pll_rst++;
    end
  endtask

  // ****************************************
  // I2C target
  // ****************************************
  initial sda_dev = 1'b1;

  always @(negedge sda) if (scl) begin
    if (up_cnt < RDY_CYC) errs++;
    in_frame = 1'b1;
    bitn = 0;
    byten = 0;
  end

  always @(posedge sda) if (scl) in_frame = 1'b0;

  always @(posedge scl) if (in_frame && bitn < 8) begin
    sh = {sh[6:0], sda};
    bitn++;
  end

  // Acknowledge is held from the eighth falling clock edge to the ninth
  always @(negedge scl) if (in_frame) begin
    if (bitn == 8) begin
      bitn = 9;
      ack = !nack_en && power_down_n_pin && (byten != 0 || sh == {DEV_ADDR, 1'b0});
      if (byten == 1) reg_a = sh;
      if (byten == 2 && ack) wr(reg_a, sh);
      byten++;
      sda_dev = !ack;
    end else if (bitn == 9) begin
      sda_dev = 1'b1;
      bitn = 0;
    end
  end
endmodule

//--- dv/tb_sps_ctrl.sv
`timescale 1ns/1ps
module tb_sps_ctrl;
  import sps_pkg::*;
  localparam int unsigned RDY = 40;
  localparam int unsigned HRST = 40;
  logic clk, resetn, run_en, hard_reset_req, tmds_clk_stable, supply_drop, nack_en;
  logic [7:0] freq_rst_cfg;
  logic [7:0] ramp_cyc;
  logic seq_ready, seq_busy, seq_error, supply_1v8_en, termination_supply_en, supply_1v1_en;
  logic power_down_n_pin, hdmi_input_en, gpio_release, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic sda_dev;
  logic [2:0] supply_good;
  logic [15:0] exp_q [$];
  int fails = 0;
  int comparisons = 0;
  // Pull-ups on both lines; the design only ever pulls low
  wire scl = scl_oe_n ? 1'b1 : scl_o;
  wire sda = (sda_oe_n ? 1'b1 : sda_o) & sda_dev;

  sps_ctrl #(.I2C_RDY_CYC(RDY), .HRST_CYC(HRST)) sps_ctrl_i (
    .clk(clk), .resetn(resetn), .run_en(run_en), .hard_reset_req(hard_reset_req),
    .freq_rst_cfg(freq_rst_cfg), .seq_ready(seq_ready), .seq_busy(seq_busy),
    .seq_error(seq_error), .supply_1v8_en(supply_1v8_en),
    .termination_supply_en(termination_supply_en), .supply_1v1_en(supply_1v1_en),
    .supply_good(supply_good), .power_down_n_pin(power_down_n_pin),
    .hdmi_input_en(hdmi_input_en), .gpio_release(gpio_release),
    .tmds_clk_stable(tmds_clk_stable), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
  );

  sps_dev_model #(.RDY_CYC(RDY), .RST_CYC(HRST), .DEV_ADDR(I2C_DEV_ADDR_DEF)) sps_dev_model_i (
    .clk(clk), .supply_1v8_en(supply_1v8_en), .termination_supply_en(termination_supply_en),
    .supply_1v1_en(supply_1v1_en), .ramp_cyc(ramp_cyc), .supply_drop(supply_drop),
    .supply_good(supply_good), .power_down_n_pin(power_down_n_pin),
    .hdmi_input_en(hdmi_input_en), .gpio_release(gpio_release),
    .tmds_clk_stable(tmds_clk_stable), .nack_en(nack_en), .scl(scl), .sda(sda),
    .sda_dev(sda_dev)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic cond(input int sel);
    case (sel)
      0: cond = seq_ready === 1'b1;
      1: cond = seq_error === 1'b1;
      2: cond = power_down_n_pin === 1'b0;
      3: cond = sps_dev_model_i.wr_q.size() > 0;
      default: cond = sps_dev_model_i.wr_q.size() >= 2;
    endcase
  endfunction

  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_for(input int sel, input int lim);
    int n = 0;
    while (!cond(sel) && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      fails++;
      test_done();
    end
  endtask

  // Reference write list built from the register orders, not from the design
  task automatic plan_writes();
    logic [7:0] pg [2] = '{8'h10, 8'h14};
    exp_q.push_back({8'h5b, freq_rst_cfg & ~8'h20});
    exp_q.push_back(16'h1602);
    foreach (pg[i]) begin
      exp_q.push_back({8'h40, pg[i]});
      exp_q.push_back(16'h4149);
      exp_q.push_back(16'h4210);
      exp_q.push_back(16'h4200);
    end
  endtask

  task automatic drain();
    while (sps_dev_model_i.wr_q.size() > 0) begin
      check(sps_dev_model_i.wr_q.pop_front(), exp_q.pop_front());
    end
    check(exp_q.size(), 0);
  endtask

  task automatic pulse_hard_reset();
    hard_reset_req = 1'b1;
    @(negedge clk);
    hard_reset_req = 1'b0;
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    resetn = 1'b0;
    run_en = 1'b0;
    hard_reset_req = 1'b0;
    tmds_clk_stable = 1'b0;
    supply_drop = 1'b0;
    nack_en = 1'b0;
    freq_rst_cfg = 8'h00;
    ramp_cyc = 8'h04;
    void'($urandom(3946));
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    check({supply_1v8_en, power_down_n_pin, scl_oe_n, sda_oe_n}, 4'h3);
    // Full bring-up with the TMDS clock held off until sequence A is over
    freq_rst_cfg = 8'($urandom());
    ramp_cyc = 8'($urandom_range(2, 30));
    plan_writes();
    run_en = 1'b1;
    wait_for(4, 20000);
    repeat (3000) @(negedge clk);
    check(sps_dev_model_i.wr_q.size(), 2);
    check(seq_ready, 1'b0);
    tmds_clk_stable = 1'b1;
    wait_for(0, 40000);
    drain();
    check({seq_busy, power_down_n_pin, hdmi_input_en, gpio_release}, 4'h7);
    check(sps_dev_model_i.hdmi_pll_rst, 1);
    check(sps_dev_model_i.link_pll_rst, 1);
    // Hard reset into a device that refuses every byte
    nack_en = 1'b1;
    pulse_hard_reset();
    repeat (3) @(negedge clk);
    check(power_down_n_pin, 1'b0);
    wait_for(1, 20000);
    check({seq_ready, power_down_n_pin, sps_dev_model_i.wr_q.size() == 0}, 3'h3);
    // Recovery from the error state by a second hard reset
    nack_en = 1'b0;
    freq_rst_cfg = 8'($urandom()) | 8'h20;
    plan_writes();
    pulse_hard_reset();
    wait_for(0, 40000);
    drain();
    check({seq_error, seq_ready}, 2'h1);
    check(sps_dev_model_i.hdmi_pll_rst, 2);
    check(sps_dev_model_i.link_pll_rst, 2);
    // Supply loss in mid sequence
    tmds_clk_stable = 1'b0;
    pulse_hard_reset();
    wait_for(3, 20000);
    supply_drop = 1'b1;
    wait_for(2, 8);
    repeat (4) @(negedge clk);
    check({supply_1v8_en, termination_supply_en, supply_1v1_en, seq_ready}, 4'h8);
    supply_drop = 1'b0;
    repeat (10) @(negedge clk);
    check(supply_1v8_en, 1'b1);
    run_en = 1'b0;
    repeat (10) @(negedge clk);
    check({power_down_n_pin, supply_1v8_en, seq_busy, scl_o, sda_o}, 5'h00);
    check(sps_dev_model_i.errs, 0);
    test_done();
  end
endmodule
